// *** rtl/rupp_pkg.sv ***
package rupp_pkg;
  localparam logic [31:0] RUPP_ADDR_PROG_BASE = 32'h0000_0000;
  localparam logic [31:0] RUPP_ADDR_DATA_BASE = 32'h0000_0004;
  localparam logic [31:0] RUPP_ADDR_RAM_SIZE = 32'h0000_0008;
  localparam logic [31:0] RUPP_ADDR_STATUS = 32'h0000_000C;
  localparam int RUPP_FIELD_LSB = 10;
  localparam int RUPP_FIELD_MSB = 15;
  localparam logic [31:0] RUPP_FIELD_MASK = 32'h0000_FC00;
  localparam logic [31:0] RUPP_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] RUPP_RAM_SIZE_DEFAULT = 32'h0001_0000;
  localparam logic [1:0] RUPP_RESP_OKAY = 2'b00;
  localparam logic [1:0] RUPP_RESP_SLVERR = 2'b10;
  localparam int RUPP_STAT_BASE_ZERO = 0;
  localparam int RUPP_STAT_NOT_ABOVE_DATA = 1;
  localparam int RUPP_STAT_ABOVE_SIZE = 2;
endpackage

// *** rtl/rupp_part_if.sv ***
`timescale 1ns/1ps
interface rupp_part_if;
  logic [31:0] progBase;
  logic [31:0] dataBase;
  logic [31:0] ramSize;
  logic kernelOnly;
  logic notAboveData;
  logic aboveSize;
  modport regs (output progBase, output dataBase, output ramSize, input kernelOnly, input notAboveData,
    input aboveSize);
  modport check (input progBase, input dataBase, input ramSize, output kernelOnly, output notAboveData,
    output aboveSize);
endinterface

// *** rtl/rupp_part_check.sv ***
`timescale 1ns/1ps
module rupp_part_check (
  rupp_part_if.check part
);
  import rupp_pkg::*;
  // zero base means no user program region at all
  assign part.kernelOnly = (part.progBase == RUPP_RESET_VALUE);
  // software's duty; flagged so misprogramming is visible
  assign part.notAboveData = !part.kernelOnly && (part.progBase <= part.dataBase);
  // software's duty; flagged so misprogramming is visible
  assign part.aboveSize = part.progBase > part.ramSize;
endmodule // rupp_part_check

// *** rtl/rupp_top.sv ***
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module rupp_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] userProgramBase,
  output logic kernelOnly,
  output logic userProgStart
);
  import rupp_pkg::*;

  rupp_part_if part ();

  logic [5:0] progField_r;
  logic [31:0] dataBase_r;
  logic [31:0] ramSize_r;
  logic [31:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHeld_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic doWrite;
  logic doRead;
  logic [31:0] progMerged;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
      input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // low ten bits and upper half are not flops at all
  function automatic logic [31:0] prog_word(input logic [5:0] f);
    return {16'h0000, f, 10'h000};
  endfunction

  // one shared decode keeps writes, reads and responses in agreement
  function automatic logic is_mapped(input logic [31:0] a);
    if (a[31:8] != 24'h00_0000 || a[1:0] != 2'b00) begin
      return 1'b0;
    end else if (a[7:2] <= RUPP_ADDR_STATUS[7:2]) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic hits(input logic [31:0] a, input logic [31:0] off);
    return is_mapped(a) && (a[7:2] == off[7:2]);
  endfunction

  assign progMerged = merge_bytes(prog_word(progField_r), wData_r, wStrb_r);
  assign part.progBase = prog_word(progField_r);
  assign part.dataBase = dataBase_r;
  assign part.ramSize = ramSize_r;

  rupp_part_check rupp_part_check_i (
    .part(part)
  );

  // address and data may arrive in either order; each is latched alone
  // ready drops while frozen, so nothing is taken that the flops would miss
  assign s_axi_awready = clkEn && !awHeld_r && !bValid_r;
  assign s_axi_wready = clkEn && !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign s_axi_arready = clkEn && !rValid_r;
  assign doRead = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 32'h0000_0000;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      progField_r <= RUPP_RESET_VALUE[RUPP_FIELD_MSB:RUPP_FIELD_LSB];
      dataBase_r <= RUPP_RESET_VALUE;
      ramSize_r <= RUPP_RAM_SIZE_DEFAULT;
    end else if (clkEn && doWrite) begin
      if (hits(awAddr_r, RUPP_ADDR_PROG_BASE)) begin
        // only bits 15..10 stored, upper bits dropped
        progField_r <= progMerged[RUPP_FIELD_MSB:RUPP_FIELD_LSB];
      end else if (hits(awAddr_r, RUPP_ADDR_DATA_BASE)) begin
        dataBase_r <= merge_bytes(dataBase_r, wData_r, wStrb_r) & RUPP_FIELD_MASK;
      end else if (hits(awAddr_r, RUPP_ADDR_RAM_SIZE)) begin
        ramSize_r <= merge_bytes(ramSize_r, wData_r, wStrb_r);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bValid_r <= 1'b0;
      bResp_r <= RUPP_RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r <= (is_mapped(awAddr_r) && awAddr_r[7:2] != RUPP_ADDR_STATUS[7:2]) ? RUPP_RESP_OKAY
          : RUPP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RUPP_RESP_OKAY;
    end else if (clkEn) begin
      if (doRead) begin
        rValid_r <= 1'b1;
        rResp_r <= is_mapped(s_axi_araddr) ? RUPP_RESP_OKAY : RUPP_RESP_SLVERR;
        if (!is_mapped(s_axi_araddr)) begin
          rData_r <= 32'h0000_0000;
        end else if (s_axi_araddr[7:2] == RUPP_ADDR_PROG_BASE[7:2]) begin
          rData_r <= prog_word(progField_r);
        end else if (s_axi_araddr[7:2] == RUPP_ADDR_DATA_BASE[7:2]) begin
          rData_r <= dataBase_r;
        end else if (s_axi_araddr[7:2] == RUPP_ADDR_RAM_SIZE[7:2]) begin
          rData_r <= ramSize_r;
        end else begin
          rData_r <= {29'h0000_0000, part.aboveSize, part.notAboveData, part.kernelOnly};
        end
      end else if (s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign userProgramBase = prog_word(progField_r);
  assign kernelOnly = part.kernelOnly;
  // user program region begins at the base only when one exists
  assign userProgStart = !part.kernelOnly;

  property p_low_zero;
    @(posedge clk) disable iff (!nrst)
      userProgramBase[9:0] == 10'h000;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits of base not zero");

  property p_upper_idle;
    @(posedge clk) disable iff (!nrst)
      userProgramBase[31:16] == 16'h0000;
  endproperty
  a_upper_idle: assert property (p_upper_idle) else $error("upper half of base nonzero");

  property p_upper_zero;
    @(posedge clk) disable iff (!nrst) rValid_r && !$past(rValid_r) && $past(s_axi_araddr) == RUPP_ADDR_PROG_BASE
      |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half of base read nonzero");

  // the read path must show exactly the word the outputs show
  property p_read_base;
    @(posedge clk) disable iff (!nrst)
      doRead && hits(s_axi_araddr, RUPP_ADDR_PROG_BASE) |=> s_axi_rdata == $past(userProgramBase);
  endproperty
  a_read_base: assert property (p_read_base) else $error("base read differs from base");

  property p_write_field;
    @(posedge clk) disable iff (!nrst) doWrite && clkEn && awAddr_r == RUPP_ADDR_PROG_BASE && wStrb_r == 4'hF
      |=> userProgramBase == ($past(wData_r) & RUPP_FIELD_MASK);
  endproperty
  a_write_field: assert property (p_write_field) else $error("base field did not take write");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
      !doWrite |=> $stable(userProgramBase);
  endproperty
  a_hold: assert property (p_hold) else $error("base changed without write");

  property p_kernel;
    @(posedge clk) disable iff (!nrst)
      kernelOnly == (userProgramBase == 32'h0000_0000) && userProgStart != kernelOnly;
  endproperty
  a_kernel: assert property (p_kernel) else $error("kernel-only flag wrong");

  property p_reset_clear;
    @(posedge clk)
      $rose(nrst) |-> userProgramBase == 32'h0000_0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("base not cleared by reset");

  property p_bus_reset;
    @(posedge clk)
      $rose(nrst) |-> !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("response pending after reset");

  // a low enable must leave the base and both response valids where they were
  property p_freeze;
    @(posedge clk) disable iff (!nrst)
      !clkEn |=> $stable(userProgramBase) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_b_hold;
    @(posedge clk) disable iff (!nrst)
      s_axi_bvalid && !(s_axi_bready && clkEn) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

  property p_r_hold;
    @(posedge clk) disable iff (!nrst)
      s_axi_rvalid && !(s_axi_rready && clkEn) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped early");

  property p_b_answer;
    @(posedge clk) disable iff (!nrst)
      doWrite && clkEn |=> s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");

  property p_r_answer;
    @(posedge clk) disable iff (!nrst)
      doRead |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read response late");

  property p_unmapped_read;
    @(posedge clk) disable iff (!nrst)
      doRead && !is_mapped(s_axi_araddr) |=> s_axi_rresp == RUPP_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

  property p_busy_refuse;
    @(posedge clk) disable iff (!nrst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while response pending");

  c_write: cover property (@(posedge clk) disable iff (!nrst) doWrite && awAddr_r == RUPP_ADDR_PROG_BASE);
  c_read: cover property (@(posedge clk) disable iff (!nrst) s_axi_rvalid && s_axi_rready);
  c_region: cover property (@(posedge clk) disable iff (!nrst) $fell(kernelOnly));
  c_slverr: cover property (@(posedge clk) disable iff (!nrst) s_axi_bvalid && s_axi_bresp == RUPP_RESP_SLVERR);
  c_freeze: cover property (@(posedge clk) disable iff (!nrst) !clkEn && s_axi_awvalid);
endmodule // rupp_top

// *** tb/tb_ram_user_program_partition.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin errTotal++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_ram_user_program_partition;
  import rupp_pkg::*;
  logic clk, nrst, clkEn;
  logic [31:0] awaddr, wdata, araddr, rdata, userProgramBase;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic kernelOnly, userProgStart;
  logic [15:0] lfsr = 16'h2117;
  logic [31:0] model;
  logic [33:0] expR[$];
  logic [1:0] expB[$];
  int errTotal = 0;
  int checkCount = 0;
  rupp_top rupp_top_i (.clk(clk), .nrst(nrst), .clkEn(clkEn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .userProgramBase(userProgramBase),
    .kernelOnly(kernelOnly), .userProgStart(userProgStart));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // responses are judged here, in order, against what the driver noted
  always @(posedge clk) begin : watch
    logic [33:0] e;
    logic [1:0] eb;
    if (nrst && rvalid && rready) begin
      e = expR.pop_front();
      `CHK(rdata, e[31:0])
      `CHK(rresp, e[33:32])
    end
    if (nrst && bvalid && bready) begin
      eb = expB.pop_front();
      `CHK(bresp, eb)
    end
  end
  task automatic giveVerdict();
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    expB.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) errTotal++;
  endtask
  task automatic axiRead(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    expR.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) errTotal++;
  endtask
  task automatic checkOut();
    `CHK(userProgramBase, model)
    `CHK(kernelOnly, model == 32'h0000_0000)
    `CHK(userProgStart, model != 32'h0000_0000)
  endtask
  // byte lanes merge, then only the writable field survives
  task automatic wrBase(input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    model = ((model & ~m) | (d & m)) & RUPP_FIELD_MASK;
    axiWrite(RUPP_ADDR_PROG_BASE, d, s, RUPP_RESP_OKAY);
    axiRead(RUPP_ADDR_PROG_BASE, model, RUPP_RESP_OKAY);
    checkOut();
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
  initial begin
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, arvalid} = '0;
    // responses are always welcome, so bready and rready never toggle
    bready = 1'b1;
    rready = 1'b1;
    nrst = 1'b0;
    clkEn = 1'b1;
    model = RUPP_RESET_VALUE;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axiRead(RUPP_ADDR_PROG_BASE, RUPP_RESET_VALUE, RUPP_RESP_OKAY);
    checkOut();
    axiRead(RUPP_ADDR_STATUS, 32'h0000_0001, RUPP_RESP_OKAY);
    wrBase(32'hFFFF_FFFF, 4'hF);
    wrBase(32'h0000_03FF, 4'hF);
    wrBase(32'hFFFF_FFFF, 4'h2);
    wrBase(32'h0000_0000, 4'h1);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsrNext(lfsr);
      wrBase({lfsr, ~lfsr}, lfsr[15:12]);
    end
    axiWrite(RUPP_ADDR_DATA_BASE, 32'hFFFF_83FF, 4'hF, RUPP_RESP_OKAY);
    axiRead(RUPP_ADDR_DATA_BASE, 32'h0000_8000, RUPP_RESP_OKAY);
    wrBase(32'h0000_4000, 4'hF);
    axiRead(RUPP_ADDR_STATUS, 32'h0000_0002, RUPP_RESP_OKAY);
    // a size below the base breaks the software duty and must be flagged
    axiWrite(RUPP_ADDR_RAM_SIZE, 32'h0000_2000, 4'hF, RUPP_RESP_OKAY);
    axiRead(RUPP_ADDR_RAM_SIZE, 32'h0000_2000, RUPP_RESP_OKAY);
    axiRead(RUPP_ADDR_STATUS, 32'h0000_0006, RUPP_RESP_OKAY);
    axiWrite(32'h0000_0010, 32'hFFFF_FFFF, 4'hF, RUPP_RESP_SLVERR);
    axiWrite(RUPP_ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, RUPP_RESP_SLVERR);
    axiWrite(32'h0000_0001, 32'hFFFF_FFFF, 4'hF, RUPP_RESP_SLVERR);
    axiRead(32'h0000_0002, 32'h0000_0000, RUPP_RESP_SLVERR);
    axiRead(RUPP_ADDR_PROG_BASE, model, RUPP_RESP_OKAY);
    // a frozen block takes nothing until the enable returns
    clkEn <= 1'b0;
    fork begin
      repeat (4) @(posedge clk);
      clkEn <= 1'b1;
    end join_none
    wrBase(32'h0000_0800, 4'h2);
    // a reset in mid-run must drop the field whatever was written
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    model = RUPP_RESET_VALUE;
    axiRead(RUPP_ADDR_PROG_BASE, RUPP_RESET_VALUE, RUPP_RESP_OKAY);
    checkOut();
    repeat (2) @(posedge clk);
    `CHK(expR.size() + expB.size(), 0)
    giveVerdict();
  end
endmodule // tb_ram_user_program_partition
